// ===== alarm_integ_regs.svh
/*
 * Register map, field positions, reset values and interval timing of the
 * receive red and yellow alarm integrator for one E1 channel.
 * Assumes the includer wants plain `define constants.
 */
// Contract
// - Split monitoring into back-to-back 4 ms intervals
// - Interval valid when any frame loss seen
// - Valid loss intervals count up; 25 declares red
// - Clean intervals count down; zero removes red
// - Flag every interval holding the yellow pattern
// - Yellow intervals count up; 80 declares yellow
// - Clean intervals count down; zero removes yellow
// - Enable bit 2 gates red change interrupt
// - Enable bit 0 gates yellow change interrupt
// - Block enable bit 1 gates all alarm interrupts
// - Interrupt needs both per-alarm and block enables
// - Status bit 7 shows declared red alarm
// - Status bit 2 flags red state change
// - Clear flags by read or by write, selectable
// - Change flags hold until software clears them
// - Status bit 0 flags yellow state change
`ifndef ALARM_INTEG_REGS_SVH
`define ALARM_INTEG_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_BLOCK_IRQ_ENABLE 6'h01
`define IDX_ALARM_ERROR_STATUS 6'h02
`define IDX_ALARM_ERROR_IRQ_ENABLE 6'h03
`define IDX_IRQ_CONTROL 6'h04

// Field positions
`define BIT_BLOCK_ALARM_EN 1
`define BIT_STATUS_RED_STATE 7
`define BIT_STATUS_RED_CHG 2
`define BIT_STATUS_YEL_CHG 0
`define BIT_EN_RED_CHG 2
`define BIT_EN_YEL_CHG 0
`define BIT_CLEAR_ON_READ 0

// Reset values
`define RST_BLOCK_IRQ_ENABLE 8'h00
`define RST_ALARM_ERROR_IRQ_ENABLE 8'h00
`define RST_IRQ_CONTROL 1'h0

// Interval timing and declaration thresholds
`define FRAME_PERIOD_US 125
`define INTERVAL_US 4000
`define FRAMES_PER_INTERVAL (`INTERVAL_US / `FRAME_PERIOD_US)
`define RED_DECLARE_COUNT 25
`define YEL_DECLARE_COUNT 80

`endif

// ===== alarm_integ_pkg.sv
/*
 * Types shared by the alarm integrator core and its flag counters.
 * Assumes alarm_integ_regs.svh is on the include path.
 */
package alarm_integ_pkg;

   // State of one flag counter
   typedef struct packed {
      logic [6:0] count;   // Saturating interval tally
      logic alarm;         // Declared alarm
      logic changed;       // One-cycle change pulse
   } integ_state_t;

   // State of the channel core and its register file
   typedef struct packed {
      logic waitrequest;      // Bus stall, low for the answer cycle
      logic [31:0] readdata;  // Captured read word
      logic [4:0] frame_cnt;  // Frames within the interval
      logic lof_seen;         // Frame loss seen this interval
      logic yel_seen;         // Yellow pattern seen this interval
      logic [7:0] blk_en;     // Block interrupt enables
      logic [7:0] irq_en;     // Per-alarm interrupt enables
      logic clear_on_read;    // Status read clears change flags
      logic chg_red;          // Sticky red change flag
      logic chg_yel;          // Sticky yellow change flag
      logic red_alarm;        // Mirrored red alarm
      logic yel_alarm;        // Mirrored yellow alarm
      logic irq;              // Interrupt line
   } core_state_t;

endpackage

// ===== alarm_integ_if.sv
/*
 * Carrier between the channel core and one flag counter.
 * Assumes both ends share the core clock.
 */
`timescale 1ns/10ps
interface alarm_integ_if;
   logic interval_end;  // Interval closes this cycle
   logic hit;           // Interval carried the condition
   logic alarm;         // Declared alarm
   logic changed;       // Alarm changed state, one cycle
   modport core (output interval_end, output hit, input alarm, input changed);
   modport integ (input interval_end, input hit, output alarm, output changed);
endinterface

// ===== alarm_flag_integrator.sv
/*
 * Up/down flag counter that declares and removes one alarm.
 * Assumes interval_end is a one-cycle pulse from the core.
 */
`timescale 1ns/10ps
`include "alarm_integ_regs.svh"
module alarm_flag_integrator #(
   parameter logic [6:0] THRESH = 7'(`RED_DECLARE_COUNT)
) (
   input wire logic clk,
   input wire logic srst,
   alarm_integ_if.integ link
);
   alarm_integ_pkg::integ_state_t st_q;  // Registered state
   alarm_integ_pkg::integ_state_t st_d;  // Next state

   // Count once per interval, saturating both ways
   always_comb begin
      st_d = st_q;
      st_d.changed = 1'b0;
      if (link.interval_end) begin
         if (link.hit && st_q.count < THRESH) begin
            st_d.count = st_q.count + 7'h01;
         end else if (!link.hit && st_q.count != 7'h00) begin
            st_d.count = st_q.count - 7'h01;
         end
      end
      // Declare at threshold, remove at zero
      if (!st_q.alarm && st_d.count == THRESH) begin
         st_d.alarm = 1'b1;
         st_d.changed = 1'b1;
      end else if (st_q.alarm && st_d.count == 7'h00) begin
         st_d.alarm = 1'b0;
         st_d.changed = 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign link.alarm = st_q.alarm;
   assign link.changed = st_q.changed;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_count_bound: assert property (st_q.count <= THRESH)
      else $error("flag counter above threshold");
   a_declare_at: assert property ($rose(st_q.alarm) |-> st_q.count == THRESH)
      else $error("alarm declared off threshold");
   a_remove_at: assert property ($fell(st_q.alarm) |-> st_q.count == 7'h00)
      else $error("alarm removed above zero");
   a_count_step: assert property (
      link.interval_end && link.hit && st_q.count < THRESH
      |=> st_q.count == $past(st_q.count) + 7'h01)
      else $error("hit interval did not count up");
endmodule

// ===== alarm_integ_core.sv
/*
 * Receive red and yellow alarm integration for one E1 channel, with its
 * alarm status and interrupt registers on an Avalon-MM slave.
 * Assumes frame_start pulses once per received 125 us frame, and that
 * lof_in and yellow_pattern_in come from the frame synchroniser in the
 * same clock domain.
 */
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "alarm_integ_regs.svh"
module alarm_integ_core #(
   parameter int INTERVAL_FRAMES = `FRAMES_PER_INTERVAL,
   parameter logic [6:0] RED_COUNT = 7'(`RED_DECLARE_COUNT),
   parameter logic [6:0] YEL_COUNT = 7'(`YEL_DECLARE_COUNT)
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic frame_start,
   input wire logic lof_in,
   input wire logic yellow_pattern_in,
   output logic irq,
   output logic red_alarm,
   output logic yellow_alarm
);
   // Last frame number of an interval
   localparam logic [4:0] LAST_FRAME = 5'(INTERVAL_FRAMES - 1);

   alarm_integ_pkg::core_state_t st_q;  // Registered state
   alarm_integ_pkg::core_state_t st_d;  // Next state

   alarm_integ_if red_if ();  // Red flag counter link
   alarm_integ_if yel_if ();  // Yellow flag counter link

   logic interval_end;  // Interval closes on this frame
   logic access;        // Bus transfer completes at this edge
   logic status_rd;     // Completed read of the status register
   logic status_wr;     // Completed write of the status register
   logic clr_red;       // Red change flag clear request
   logic clr_yel;       // Yellow change flag clear request

   // True when a byte address selects the given register index
   function automatic logic reg_sel(input logic [7:0] addr, input logic [5:0] idx);
      reg_sel = (addr[7:2] == idx);
   endfunction

   // Status word as software sees it
   function automatic logic [7:0] status_word(input alarm_integ_pkg::core_state_t s);
      status_word = 8'h00;
      status_word[`BIT_STATUS_RED_STATE] = s.red_alarm;
      status_word[`BIT_STATUS_RED_CHG] = s.chg_red;
      status_word[`BIT_STATUS_YEL_CHG] = s.chg_yel;
   endfunction

   // Interval framing and bus qualifiers
   always_comb begin
      interval_end = frame_start && st_q.frame_cnt == LAST_FRAME;
      access = (read || write) && !st_q.waitrequest;
      status_rd = access && read && reg_sel(address, `IDX_ALARM_ERROR_STATUS);
      status_wr = access && write && reg_sel(address, `IDX_ALARM_ERROR_STATUS);
   end

   // Clear requests; only bits the read actually returned are cleared,
   // so a change posted after the word was captured is not lost
   always_comb begin
      if (st_q.clear_on_read) begin
         clr_red = status_rd && st_q.readdata[`BIT_STATUS_RED_CHG];
         clr_yel = status_rd && st_q.readdata[`BIT_STATUS_YEL_CHG];
      end else begin
         clr_red = status_wr && writedata[`BIT_STATUS_RED_CHG];
         clr_yel = status_wr && writedata[`BIT_STATUS_YEL_CHG];
      end
   end

   // Hand interval results to the flag counters
   assign red_if.interval_end = interval_end;
   assign red_if.hit = st_q.lof_seen || lof_in;
   assign yel_if.interval_end = interval_end;
   assign yel_if.hit = st_q.yel_seen || yellow_pattern_in;

   // Red alarm flag counter
   alarm_flag_integrator #(
      .THRESH(RED_COUNT)
   ) red_cnt (
      .clk(clk),
      .srst(srst),
      .link(red_if)
   );

   // Yellow alarm flag counter
   alarm_flag_integrator #(
      .THRESH(YEL_COUNT)
   ) yel_cnt (
      .clk(clk),
      .srst(srst),
      .link(yel_if)
   );

   // Next-state logic for interval, flags, registers and bus
   always_comb begin
      st_d = st_q;

      // Frame counter wraps straight into the next interval
      if (frame_start) begin
         if (interval_end) begin
            st_d.frame_cnt = 5'h00;
         end else begin
            st_d.frame_cnt = st_q.frame_cnt + 5'h01;
         end
      end

      // Any single occurrence marks the whole interval
      if (interval_end) begin
         st_d.lof_seen = 1'b0;
         st_d.yel_seen = 1'b0;
      end else begin
         st_d.lof_seen = st_q.lof_seen || lof_in;
         st_d.yel_seen = st_q.yel_seen || yellow_pattern_in;
      end

      // Mirrored alarm states on pins; only red is also shown in status
      st_d.red_alarm = red_if.alarm;
      st_d.yel_alarm = yel_if.alarm;

      // Sticky change flags; a new change beats a clear
      st_d.chg_red = red_if.changed || (st_q.chg_red && !clr_red);
      st_d.chg_yel = yel_if.changed || (st_q.chg_yel && !clr_yel);

      // One stall cycle, then a single answer cycle
      if ((read || write) && st_q.waitrequest) begin
         st_d.waitrequest = 1'b0;
      end else begin
         st_d.waitrequest = 1'b1;
      end

      // Read word captured in the stall cycle, held for the answer
      if (read && st_q.waitrequest) begin
         st_d.readdata = 32'h0000_0000;
         if (reg_sel(address, `IDX_BLOCK_IRQ_ENABLE)) begin
            st_d.readdata[7:0] = st_q.blk_en;
         end else if (reg_sel(address, `IDX_ALARM_ERROR_STATUS)) begin
            st_d.readdata[7:0] = status_word(st_q);
         end else if (reg_sel(address, `IDX_ALARM_ERROR_IRQ_ENABLE)) begin
            st_d.readdata[7:0] = st_q.irq_en;
         end else if (reg_sel(address, `IDX_IRQ_CONTROL)) begin
            st_d.readdata[`BIT_CLEAR_ON_READ] = st_q.clear_on_read;
         end
         // Unmapped addresses read as zero
      end

      // Writes land on the answer edge only
      if (access && write) begin
         if (reg_sel(address, `IDX_BLOCK_IRQ_ENABLE)) begin
            st_d.blk_en = writedata[7:0];
         end else if (reg_sel(address, `IDX_ALARM_ERROR_IRQ_ENABLE)) begin
            st_d.irq_en = writedata[7:0];
         end else if (reg_sel(address, `IDX_IRQ_CONTROL)) begin
            st_d.clear_on_read = writedata[`BIT_CLEAR_ON_READ];
         end
         // Unmapped writes are dropped but still answered
      end

      // Level interrupt from the next flags, so it lines up with them
      st_d.irq = st_d.blk_en[`BIT_BLOCK_ALARM_EN]
         && ((st_d.chg_red && st_d.irq_en[`BIT_EN_RED_CHG])
         || (st_d.chg_yel && st_d.irq_en[`BIT_EN_YEL_CHG]));
   end

   // State register; bus idles stalled
   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= '0;
         st_q.waitrequest <= 1'b1;
         st_q.blk_en <= `RST_BLOCK_IRQ_ENABLE;
         st_q.irq_en <= `RST_ALARM_ERROR_IRQ_ENABLE;
         st_q.clear_on_read <= `RST_IRQ_CONTROL;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from flip-flops
   assign readdata = st_q.readdata;
   assign waitrequest = st_q.waitrequest;
   assign irq = st_q.irq;
   assign red_alarm = st_q.red_alarm;
   assign yellow_alarm = st_q.yel_alarm;

   // Checks on the core
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // A request held in the stall cycle is answered next cycle
   sequence s_request_stalled;
      (read || write) && waitrequest;
   endsequence

   // Completed read of the status register in clear-on-read mode
   sequence s_status_read_cor;
      read && !waitrequest && reg_sel(address, `IDX_ALARM_ERROR_STATUS)
         && st_q.clear_on_read;
   endsequence

   // Completed write of the status register in write-to-clear mode
   sequence s_status_write_woc;
      write && !waitrequest && reg_sel(address, `IDX_ALARM_ERROR_STATUS)
         && !st_q.clear_on_read;
   endsequence

   a_bus_answer: assert property (s_request_stalled |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not one cycle after stall");
   a_interval_close: assert property (
      interval_end |-> frame_start && st_q.frame_cnt == LAST_FRAME)
      else $error("interval closed on wrong frame");
   // Guards the frame counter itself, not just the closing decode
   a_frame_advance: assert property (
      frame_start && !interval_end
      |=> st_q.frame_cnt == $past(st_q.frame_cnt) + 5'h01)
      else $error("frame count did not advance");
   a_interval_restart: assert property (
      interval_end |=> st_q.frame_cnt == 5'h00 && !st_q.lof_seen)
      else $error("interval did not restart");
   a_loss_caught: assert property (lof_in && !interval_end |=> st_q.lof_seen)
      else $error("frame loss not recorded");
   a_yellow_caught: assert property (
      yellow_pattern_in && !interval_end |=> st_q.yel_seen)
      else $error("yellow pattern not recorded");
   a_red_state_bit: assert property (##1 red_alarm == $past(red_if.alarm))
      else $error("red state bit out of step");
   a_red_change: assert property (red_if.changed |=> st_q.chg_red)
      else $error("red change flag not set");
   a_yel_change: assert property (yel_if.changed |=> st_q.chg_yel)
      else $error("yellow change flag not set");
   a_flag_holds: assert property (st_q.chg_red && !clr_red |=> st_q.chg_red)
      else $error("red change flag dropped uncleared");
   a_read_clears: assert property (
      s_status_read_cor ##0 (st_q.readdata[`BIT_STATUS_RED_CHG] && !red_if.changed)
      |=> !st_q.chg_red)
      else $error("status read did not clear red flag");
   a_write_clears: assert property (
      s_status_write_woc ##0 (writedata[`BIT_STATUS_YEL_CHG] && !yel_if.changed)
      |=> !st_q.chg_yel)
      else $error("status write did not clear yellow flag");
   a_irq_master: assert property (
      irq |-> st_q.blk_en[`BIT_BLOCK_ALARM_EN])
      else $error("interrupt without block enable");
   a_irq_red: assert property (
      st_q.chg_red && st_q.irq_en[`BIT_EN_RED_CHG]
      && st_q.blk_en[`BIT_BLOCK_ALARM_EN] |-> irq)
      else $error("enabled red change gave no interrupt");
   a_irq_yel: assert property (
      st_q.chg_yel && st_q.irq_en[`BIT_EN_YEL_CHG]
      && st_q.blk_en[`BIT_BLOCK_ALARM_EN] |-> irq)
      else $error("enabled yellow change gave no interrupt");
   a_irq_cause: assert property (
      irq |-> (st_q.chg_red && st_q.irq_en[`BIT_EN_RED_CHG])
      || (st_q.chg_yel && st_q.irq_en[`BIT_EN_YEL_CHG]))
      else $error("interrupt without enabled change");
endmodule

// ===== framer_sync_model.sv
/*
 * Stand-in for the receive frame synchroniser: frame pulses, frame loss
 * and yellow pattern marks. Assumes the bench changes its commands only
 * at the edge that closes an interval.
 */
`timescale 1ns/10ps
module framer_sync_model #(
   parameter int GAP = 8,
   parameter int FRAMES = 2
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic lof_cmd,
   input wire logic yel_cmd,
   input wire logic [3:0] lof_pos,
   input wire logic [3:0] yel_pos,
   output logic frame_start,
   output logic lof_in,
   output logic yellow_pattern_in,
   output logic int_end
);
   logic [7:0] cyc_q; // Cycle within the interval

   // Interval timer, restarted at once after each close
   always_ff @(posedge clk) begin
      if (srst || int_end) begin
         cyc_q <= 8'h00;
      end else begin
         cyc_q <= cyc_q + 8'h01;
      end
   end

   // One frame pulse every GAP cycles
   assign frame_start = !srst && (int'(cyc_q) % GAP == GAP - 1);
   assign int_end = !srst && (int'(cyc_q) == GAP * FRAMES - 1);
   // A single-cycle mark only; a level would hide a missed sample
   assign lof_in = lof_cmd && (cyc_q[3:0] == lof_pos);
   assign yellow_pattern_in = yel_cmd && (cyc_q[3:0] == yel_pos);
endmodule

// ===== alarm_integ_core_test.sv
/*
 * Self-checking bench: random intervals and register traffic on the
 * alarm integrator. Assumes the design files and framer_sync_model.
 */
`timescale 1ns/10ps
`include "alarm_integ_regs.svh"
module alarm_integ_core_test;
   localparam int RC = 3; // Shortened red threshold
   localparam int YC = 4; // Shortened yellow threshold
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest, frame_start, lof_in, yellow_pattern_in, irq, int_end;
   logic red_alarm, yellow_alarm;
   logic lof_cmd = 1'b0;
   logic yel_cmd = 1'b0;
   logic [3:0] lof_pos = 4'h0;
   logic [3:0] yel_pos = 4'h0;
   int mismatches = 0;
   int samples_checked = 0;
   int seed = 32'h4f2e;
   int red_cnt, yel_cnt; // Reference counters
   logic red_a, yel_a, red_p1, yel_p1, chg_red, chg_yel, cor;
   logic [7:0] blk, en;
   logic [7:0] addrs [6] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h00, 8'h20};
   wire st_hit = !waitrequest && (address[7:2] == `IDX_ALARM_ERROR_STATUS);
   wire clr_r = st_hit && read && cor;
   wire clr_w = st_hit && write && !cor;

   always #5 clk = ~clk;

   alarm_integ_core #(.INTERVAL_FRAMES(2), .RED_COUNT(7'(RC)), .YEL_COUNT(7'(YC))) i_dut (
      .clk(clk), .srst(srst), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .frame_start(frame_start), .lof_in(lof_in), .yellow_pattern_in(yellow_pattern_in),
      .irq(irq), .red_alarm(red_alarm), .yellow_alarm(yellow_alarm));

   framer_sync_model #(.GAP(8), .FRAMES(2)) i_sync (
      .clk(clk), .srst(srst), .lof_cmd(lof_cmd), .yel_cmd(yel_cmd), .lof_pos(lof_pos),
      .yel_pos(yel_pos), .frame_start(frame_start), .lof_in(lof_in),
      .yellow_pattern_in(yellow_pattern_in), .int_end(int_end));

   // Saturating up/down step of a flag counter
   function automatic int step(int c, logic h, int t);
      if (h) return (c < t) ? c + 1 : t;
      return (c > 0) ? c - 1 : 0;
   endfunction

   // Declare at threshold, remove at zero, else hold
   function automatic logic alarm(logic a, int n, int t);
      return (n == t) ? 1'b1 : ((n == 0) ? 1'b0 : a);
   endfunction

   // Expected register word from the reference state
   function automatic logic [31:0] reg_exp(logic [7:0] a);
      case (a[7:2])
         `IDX_BLOCK_IRQ_ENABLE: return {24'h0, blk};
         `IDX_ALARM_ERROR_STATUS: return {24'h0, red_p1, 4'h0, chg_red, 1'b0, chg_yel};
         `IDX_ALARM_ERROR_IRQ_ENABLE: return {24'h0, en};
         `IDX_IRQ_CONTROL: return {31'h0, cor};
         default: return 32'h0;
      endcase
   endfunction

   // Reference integrator; alarms move at the closing edge,
   // pins and change flags one edge after it
   always @(posedge clk) begin
      if (srst) begin
         {red_cnt, yel_cnt} <= '0;
         {red_a, yel_a, red_p1, yel_p1} <= '0;
         {chg_red, chg_yel, cor, blk, en} <= '0;
      end else begin
         if (int_end) begin
            red_cnt <= step(red_cnt, lof_cmd, RC);
            yel_cnt <= step(yel_cnt, yel_cmd, YC);
            red_a <= alarm(red_a, step(red_cnt, lof_cmd, RC), RC);
            yel_a <= alarm(yel_a, step(yel_cnt, yel_cmd, YC), YC);
         end
         red_p1 <= red_a;
         yel_p1 <= yel_a;
         // A change in the clear cycle wins
         chg_red <= (red_a != red_p1) || (chg_red && !(clr_r || (clr_w && writedata[2])));
         chg_yel <= (yel_a != yel_p1) || (chg_yel && !(clr_r || (clr_w && writedata[0])));
         if (write && !waitrequest) begin
            case (address[7:2])
               `IDX_BLOCK_IRQ_ENABLE: blk <= writedata[7:0];
               `IDX_ALARM_ERROR_IRQ_ENABLE: en <= writedata[7:0];
               `IDX_IRQ_CONTROL: cor <= writedata[0];
               default: ;
            endcase
         end
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      if (mismatches == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Pins compared every cycle against the reference
   always @(negedge clk) begin
      if (!srst) begin
         check(red_alarm, red_p1);
         check(yellow_alarm, yel_p1);
         // Irq moves on the same edge as flags and enables, bus cycles included
         check(irq, blk[1] && ((chg_red && en[2]) || (chg_yel && en[0])));
      end
   end

   // One Avalon cycle, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      int n;
      @(posedge clk);
      address <= a;
      writedata <= {24'h0, d};
      write <= wr;
      read <= !wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         mismatches++;
         final_report();
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a);
      logic [31:0] e, q;
      e = reg_exp(a);
      bus(1'b0, a, 8'h00, q);
      check(q, e);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   // Wait for a closing edge, then command the next interval
   task automatic sync(input logic l, input logic y);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (int_end !== 1'b1 && n < 40);
      if (n >= 40) begin
         mismatches++;
         final_report();
      end
      @(posedge clk);
      lof_cmd <= l;
      yel_cmd <= y;
      lof_pos <= 4'($random(seed));
      yel_pos <= 4'($random(seed));
      repeat (3) @(posedge clk);
   endtask

   initial begin
      logic [31:0] r;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      foreach (addrs[i]) rd(addrs[i]);
      wr(8'h20, 8'hff);
      rd(8'h20);
      for (int i = 0; i < 4; i++) begin
         wr(8'h04, 8'($random(seed)));
         rd(8'h04);
         wr(8'h0c, 8'($random(seed)));
         rd(8'h0c);
      end
      wr(8'h04, 8'h02);
      wr(8'h0c, 8'h05);
      // Past both thresholds, then drain from saturation
      repeat (6) sync(1'b1, 1'b1);
      repeat (5) sync(1'b0, 1'b0);
      rd(8'h08);
      rd(8'h08);
      wr(8'h08, 8'h84);
      rd(8'h08);
      wr(8'h08, 8'h01);
      rd(8'h08);
      // Read-to-clear mode: declare red again, then a read clears it
      repeat (5) sync(1'b1, 1'b0);
      wr(8'h10, 8'h01);
      rd(8'h08);
      rd(8'h08);
      wr(8'h10, 8'h00);
      // Random intervals with one random register access each
      for (int i = 0; i < 80; i++) begin
         r = $random(seed);
         sync((i < 40) ? (r[1:0] != 2'h0) : (r[1:0] == 2'h0),
              (i < 40) ? (r[3:2] != 2'h0) : (r[3:2] == 2'h0));
         case (r[6:4])
            3'h0: wr(8'h04, r[15:8]);
            3'h1: wr(8'h0c, r[15:8]);
            3'h2: wr(8'h08, r[15:8]);
            3'h3: wr(8'h10, r[15:8]);
            default: rd(8'h08);
         endcase
      end
      final_report();
   end

   initial begin
      #100000;
      mismatches++;
      final_report();
   end
endmodule
